/* rtl/ars_consts.svh */
`ifndef ARS_CONSTS_SVH
`define ARS_CONSTS_SVH

// ----------------------------------------
// Instruction word fields
// ----------------------------------------
`define ARS_DEST_BIT 7
`define ARS_FADDR_MSB 6
`define ARS_LIT_MSB 7
`define ARS_OPC_MSB 13
`define ARS_OPC_LSB 8

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define ARS_OPC_SUBF 6'h02
`define ARS_OPC_XORF 6'h06
`define ARS_OPC_ROTR 6'h0c
`define ARS_OPC_ROTL 6'h0d
`define ARS_OPC_SWAP 6'h0e
`define ARS_OPC_XORL 6'h3a
`define ARS_SUBL_HI 5'h1e
`define ARS_WORD_SLEEP 14'h0063
`define ARS_DIRLD_HI 11'h00c
`define ARS_DIRLD_MIN 3'h5
`define ARS_DIRLD_MAX 3'h7

// ----------------------------------------
// Reset and clear values
// ----------------------------------------
`define ARS_ACC_RST 8'h00
`define ARS_WDOG_CLR 8'h00
`define ARS_TIMEOUT_RST 1'b1
`define ARS_PWRDN_RST 1'b1

`endif

/* rtl/ars_pkg.sv */
package ars_pkg;

    typedef enum logic [3:0] {
        op_none,
        op_rot_left,
        op_rot_right,
        op_sub_lit,
        op_sub_file,
        op_swap,
        op_xor_lit,
        op_xor_file,
        op_dir_load,
        op_sleep
    } ars_op_t;

endpackage

/* rtl/ars_alu.sv */
`timescale 1ns/1ps
`default_nettype none

module ars_alu (
    input wire ars_pkg::ars_op_t op,
    input wire logic [7:0] acc,
    input wire logic [7:0] fdata,
    input wire logic [7:0] lit,
    input wire logic c_in,
    output logic [7:0] result,
    output logic c_out,
    output logic dc_out
);

    // Carry out is an inverted borrow, as is digit carry
    function automatic logic [9:0] sub8(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] full;
        logic [4:0] low;
        full = {1'b0, a} + {1'b0, ~b} + 9'h001;
        low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
        sub8 = {full[8], low[4], full[7:0]};
    endfunction

    always_comb begin
        result = fdata;
        c_out = c_in;
        dc_out = 1'b0;
        unique case (op)
            ars_pkg::op_rot_left: begin
                result = {fdata[6:0], c_in};
                c_out = fdata[7];
            end
            ars_pkg::op_rot_right: begin
                result = {c_in, fdata[7:1]};
                c_out = fdata[0];
            end
            ars_pkg::op_sub_lit: begin
                {c_out, dc_out, result} = sub8(lit, acc);
            end
            ars_pkg::op_sub_file: begin
                {c_out, dc_out, result} = sub8(fdata, acc);
            end
            ars_pkg::op_swap: result = {fdata[3:0], fdata[7:4]};
            ars_pkg::op_xor_lit: result = acc ^ lit;
            ars_pkg::op_xor_file: result = acc ^ fdata;
            ars_pkg::op_dir_load: result = acc;
            ars_pkg::op_sleep: result = fdata;
            ars_pkg::op_none: result = fdata;
        endcase
    end

endmodule

`default_nettype wire

/* rtl/ars_exec.sv */
// Contract
// - Rotate left through carry; old bit 7 to carry; only carry changes.
// - File-register ops write accumulator if destination bit 0, else the register.
// - Rotate right through carry; old bit 0 to carry; only carry changes.
// - Power-down clears the power-down flag and sets the time-out flag.
// - Power-down zeroes the watchdog counter and its prescaler.
// - Power-down enters sleep with oscillator halted, in one cycle.
// - Literal minus accumulator into accumulator, updating carry, digit carry, zero.
// - Register minus accumulator to destination, updating carry, digit carry, zero.
// - Nibble exchange to destination; no status flag changes.
// - Direction load copies accumulator to selected direction register; no flags.
// - Accumulator XOR literal into accumulator; only zero flag changes.
// - Accumulator XOR register to destination; only zero flag changes.
`timescale 1ns/1ps
`default_nettype none
`include "ars_consts.svh"

module ars_exec #(
    parameter int WDOG_W = 8,
    parameter int PRE_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire logic [13:0] instr_word,
    input wire logic [7:0] file_rdata,
    input wire logic wake_pin,
    output logic [7:0] acc_q,
    output logic carry_q,
    output logic dcarry_q,
    output logic zero_q,
    output logic timeout_flag_q,
    output logic powerdown_flag_q,
    output logic [WDOG_W-1:0] watchdog_counter_q,
    output logic [PRE_W-1:0] prescaler_q,
    output logic sleep_q,
    output logic osc_run_q,
    output logic file_we_q,
    output logic [6:0] file_waddr_q,
    output logic [7:0] file_wdata_q,
    output logic dir_we_q,
    output logic [2:0] dir_sel_q,
    output logic [7:0] dir_wdata_q
);

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    function automatic ars_pkg::ars_op_t decode(input logic [13:0] w);
        logic [5:0] opc;
        opc = w[`ARS_OPC_MSB:`ARS_OPC_LSB];
        decode = ars_pkg::op_none;
        if (w == `ARS_WORD_SLEEP) begin
            decode = ars_pkg::op_sleep;
        end else if (w[13:3] == `ARS_DIRLD_HI && w[2:0] >= `ARS_DIRLD_MIN
                     && w[2:0] <= `ARS_DIRLD_MAX) begin
            decode = ars_pkg::op_dir_load;
        end else if (w[13:9] == `ARS_SUBL_HI) begin
            decode = ars_pkg::op_sub_lit;
        end else if (opc == `ARS_OPC_XORL) begin
            decode = ars_pkg::op_xor_lit;
        end else if (opc == `ARS_OPC_ROTL) begin
            decode = ars_pkg::op_rot_left;
        end else if (opc == `ARS_OPC_ROTR) begin
            decode = ars_pkg::op_rot_right;
        end else if (opc == `ARS_OPC_SUBF) begin
            decode = ars_pkg::op_sub_file;
        end else if (opc == `ARS_OPC_SWAP) begin
            decode = ars_pkg::op_swap;
        end else if (opc == `ARS_OPC_XORF) begin
            decode = ars_pkg::op_xor_file;
        end
    endfunction

    ars_pkg::ars_op_t op;
    logic take;
    logic file_op;
    logic to_file;
    logic upd_c;
    logic upd_dc;
    logic upd_z;
    logic [7:0] result;
    logic c_new;
    logic dc_new;
    logic wake_s1_q;
    logic wake_s2_q;

    // Asleep the core issues nothing; a stray strobe is dropped
    assign take = instr_valid && !sleep_q;
    assign op = take ? decode(instr_word) : ars_pkg::op_none;
    assign file_op = op == ars_pkg::op_rot_left || op == ars_pkg::op_rot_right
                     || op == ars_pkg::op_sub_file || op == ars_pkg::op_swap
                     || op == ars_pkg::op_xor_file;
    assign to_file = file_op && instr_word[`ARS_DEST_BIT];
    assign upd_c = op == ars_pkg::op_rot_left || op == ars_pkg::op_rot_right
                   || op == ars_pkg::op_sub_lit || op == ars_pkg::op_sub_file;
    assign upd_dc = op == ars_pkg::op_sub_lit || op == ars_pkg::op_sub_file;
    assign upd_z = upd_dc || op == ars_pkg::op_xor_lit || op == ars_pkg::op_xor_file;

    ars_alu u_alu (
        .op(op),
        .acc(acc_q),
        .fdata(file_rdata),
        .lit(instr_word[`ARS_LIT_MSB:0]),
        .c_in(carry_q),
        .result(result),
        .c_out(c_new),
        .dc_out(dc_new)
    );

    // ----------------------------------------
    // Result routing
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_q <= `ARS_ACC_RST;
        end else if ((file_op && !to_file) || op == ars_pkg::op_sub_lit
                     || op == ars_pkg::op_xor_lit) begin
            acc_q <= result;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            file_we_q <= 1'b0;
            file_waddr_q <= 7'h00;
            file_wdata_q <= 8'h00;
        end else begin
            file_we_q <= to_file;
            if (to_file) begin
                file_waddr_q <= instr_word[`ARS_FADDR_MSB:0];
                file_wdata_q <= result;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dir_we_q <= 1'b0;
            dir_sel_q <= 3'h0;
            dir_wdata_q <= 8'h00;
        end else begin
            dir_we_q <= op == ars_pkg::op_dir_load;
            if (op == ars_pkg::op_dir_load) begin
                dir_sel_q <= instr_word[2:0];
                dir_wdata_q <= acc_q;
            end
        end
    end

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            carry_q <= 1'b0;
            dcarry_q <= 1'b0;
            zero_q <= 1'b0;
        end else begin
            if (upd_c) begin
                carry_q <= c_new;
            end
            if (upd_dc) begin
                dcarry_q <= dc_new;
            end
            if (upd_z) begin
                zero_q <= result == 8'h00;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            timeout_flag_q <= `ARS_TIMEOUT_RST;
            powerdown_flag_q <= `ARS_PWRDN_RST;
        end else if (op == ars_pkg::op_sleep) begin
            timeout_flag_q <= 1'b1;
            powerdown_flag_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Watchdog and sleep
    // ----------------------------------------
    // Prescaler free-runs; its wrap advances the counter
    always_ff @(posedge clk) begin
        if (rst || op == ars_pkg::op_sleep) begin
            prescaler_q <= '0;
            watchdog_counter_q <= WDOG_W'(`ARS_WDOG_CLR);
        end else begin
            prescaler_q <= prescaler_q + PRE_W'(1);
            if (&prescaler_q) begin
                watchdog_counter_q <= watchdog_counter_q + WDOG_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        wake_s1_q <= wake_pin;
        wake_s2_q <= wake_s1_q;
    end

    // Wake only ends sleep; a wake level while running does nothing
    always_ff @(posedge clk) begin
        if (rst) begin
            sleep_q <= 1'b0;
            osc_run_q <= 1'b1;
        end else if (op == ars_pkg::op_sleep) begin
            sleep_q <= 1'b1;
            osc_run_q <= 1'b0;
        end else if (sleep_q && wake_s2_q) begin
            sleep_q <= 1'b0;
            osc_run_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence take_op(ars_pkg::ars_op_t o);
        op == o;
    endsequence

    sequence dozing;
        sleep_q && !osc_run_q && !file_we_q && !dir_we_q;
    endsequence

    rotl_result_a: assert property (take_op(ars_pkg::op_rot_left) |=>
        carry_q == $past(file_rdata[7]) && zero_q == $past(zero_q)
        && (file_we_q ? file_wdata_q : acc_q) == {$past(file_rdata[6:0]), $past(carry_q)})
        else $error("rotate left wrong");

    dest_route_a: assert property (file_op |=>
        file_we_q == $past(instr_word[7])
        && (!file_we_q || file_waddr_q == $past(instr_word[6:0])))
        else $error("destination routing wrong");

    rotr_result_a: assert property (take_op(ars_pkg::op_rot_right) |=>
        carry_q == $past(file_rdata[0]) && dcarry_q == $past(dcarry_q)
        && (file_we_q ? file_wdata_q : acc_q) == {$past(carry_q), $past(file_rdata[7:1])})
        else $error("rotate right wrong");

    sleep_flags_a: assert property (take_op(ars_pkg::op_sleep) |=>
        timeout_flag_q && !powerdown_flag_q)
        else $error("power-down flags wrong");

    wdog_clear_a: assert property (take_op(ars_pkg::op_sleep) |=>
        watchdog_counter_q == '0 && prescaler_q == '0)
        else $error("watchdog not cleared");

    sleep_enter_a: assert property (take_op(ars_pkg::op_sleep) ##1 !wake_s2_q |=>
        dozing)
        else $error("sleep not entered");

    sub_lit_a: assert property (take_op(ars_pkg::op_sub_lit) |=>
        acc_q == 8'($past(instr_word[7:0]) - $past(acc_q))
        && zero_q == (acc_q == 8'h00))
        else $error("literal subtract wrong");

    borrow_a: assert property (take_op(ars_pkg::op_sub_file) |=>
        carry_q == ($past(file_rdata) >= $past(acc_q))
        && dcarry_q == ($past(file_rdata[3:0]) >= $past(acc_q[3:0])))
        else $error("subtract carry wrong");

    swap_a: assert property (take_op(ars_pkg::op_swap) |=>
        $stable(carry_q) && $stable(zero_q) && $stable(dcarry_q)
        && (file_we_q ? file_wdata_q : acc_q) == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
        else $error("nibble exchange wrong");

    dir_load_a: assert property (take_op(ars_pkg::op_dir_load) |=>
        dir_we_q && dir_wdata_q == $past(acc_q) && dir_sel_q == $past(instr_word[2:0])
        && $stable(zero_q) && $stable(carry_q))
        else $error("direction load wrong");

    xor_lit_a: assert property (take_op(ars_pkg::op_xor_lit) |=>
        acc_q == ($past(acc_q) ^ $past(instr_word[7:0])) && $stable(carry_q))
        else $error("literal xor wrong");

    xor_file_a: assert property (take_op(ars_pkg::op_xor_file) |=>
        (file_we_q ? file_wdata_q : acc_q) == ($past(acc_q) ^ $past(file_rdata))
        && zero_q == (($past(acc_q) ^ $past(file_rdata)) == 8'h00) && $stable(dcarry_q))
        else $error("register xor wrong");

endmodule

`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
    $display("FAIL %s expected %h seen %h", what, exp, got); end end

module tb_top;
    logic clk, rst, instr_valid, wake_pin;
    logic [13:0] instr_word;
    logic [7:0] file_rdata, acc_q, file_wdata_q, dir_wdata_q;
    logic carry_q, dcarry_q, zero_q, timeout_flag_q, powerdown_flag_q, sleep_q, osc_run_q;
    logic file_we_q, dir_we_q;
    logic [7:0] watchdog_counter_q;
    logic [1:0] prescaler_q;
    logic [6:0] file_waddr_q;
    logic [2:0] dir_sel_q;
    int n_errors, checks_done, cycles;
    logic [7:0] e_acc;
    logic e_c, e_dc, e_z;

    // Short prescaler so the watchdog counter moves within a few cycles
    ars_exec #(.WDOG_W(8), .PRE_W(2)) i_ars_exec (
        .clk(clk), .rst(rst), .instr_valid(instr_valid), .instr_word(instr_word),
        .file_rdata(file_rdata), .wake_pin(wake_pin), .acc_q(acc_q), .carry_q(carry_q),
        .dcarry_q(dcarry_q), .zero_q(zero_q), .timeout_flag_q(timeout_flag_q),
        .powerdown_flag_q(powerdown_flag_q), .watchdog_counter_q(watchdog_counter_q),
        .prescaler_q(prescaler_q), .sleep_q(sleep_q), .osc_run_q(osc_run_q),
        .file_we_q(file_we_q), .file_waddr_q(file_waddr_q), .file_wdata_q(file_wdata_q),
        .dir_we_q(dir_we_q), .dir_sel_q(dir_sel_q), .dir_wdata_q(dir_wdata_q)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task conclude;
        $display("Errors %0d, checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Called at a falling edge; returns at the next one with results settled
    task exec(input logic [13:0] w, input logic [7:0] f);
        instr_word = w;
        file_rdata = f;
        instr_valid = 1'b1;
        @(negedge clk);
    endtask

    task idle;
        instr_valid = 1'b0;
        file_rdata = ~file_rdata;
        @(negedge clk);
    endtask

    task check_core;
        `CHK("acc", e_acc, acc_q)
        `CHK("carry", e_c, carry_q)
        `CHK("dcarry", e_dc, dcarry_q)
        `CHK("zero", e_z, zero_q)
    endtask

    // Carry and digit carry are inverted borrows
    function automatic logic [9:0] sub_calc(input logic [7:0] a, input logic [7:0] b);
        return {a >= b, a[3:0] >= b[3:0], 8'(a - b)};
    endfunction

    task set_acc(input logic [7:0] v);
        exec(14'h3a00 | {6'h00, e_acc ^ v}, 8'h00);
        e_acc = v;
        e_z = (v == 8'h00);
        check_core();
        idle();
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        check_core();
        `CHK("timeout", 1'b1, timeout_flag_q)
        `CHK("powerdown", 1'b1, powerdown_flag_q)
        `CHK("sleep", 1'b0, sleep_q)
        `CHK("osc", 1'b1, osc_run_q)
        `CHK("file_we", 1'b0, file_we_q)
        `CHK("dir_we", 1'b0, dir_we_q)
    endtask

    task t_rotate;
        set_acc(8'h00);
        exec(14'h0d85, 8'he6);
        `CHK("file_we", 1'b1, file_we_q)
        `CHK("waddr", 7'h05, file_waddr_q)
        `CHK("wdata", 8'hcc, file_wdata_q)
        e_c = 1'b1;
        check_core();
        exec(14'h0d05, 8'h80);
        e_acc = 8'h01;
        check_core();
        `CHK("file_we", 1'b0, file_we_q)
        exec(14'h0c05, 8'h02);
        e_acc = 8'h81;
        e_c = 1'b0;
        check_core();
        idle();
    endtask

    task t_sub_lit;
        logic [7:0] ks [4];
        logic [7:0] ws [4];
        logic [9:0] r;
        ks = '{8'h05, 8'h00, 8'h10, 8'hff};
        ws = '{8'h05, 8'h01, 8'h01, 8'h00};
        for (int i = 0; i < 4; i++) begin
            set_acc(ws[i]);
            exec({5'h1e, i[0], ks[i]}, 8'h00);
            r = sub_calc(ks[i], ws[i]);
            {e_c, e_dc, e_acc} = r;
            e_z = (r[7:0] == 8'h00);
            check_core();
            idle();
        end
    endtask

    task t_sub_file;
        logic [9:0] r;
        set_acc(8'h21);
        exec(14'h02ff, 8'h20);
        r = sub_calc(8'h20, 8'h21);
        `CHK("file_we", 1'b1, file_we_q)
        `CHK("waddr", 7'h7f, file_waddr_q)
        `CHK("wdata", r[7:0], file_wdata_q)
        {e_c, e_dc} = r[9:8];
        e_z = 1'b0;
        check_core();
        exec(14'h0212, 8'h21);
        {e_c, e_dc, e_acc, e_z} = {2'b11, 8'h00, 1'b1};
        check_core();
        idle();
    endtask

    task t_swap_xor;
        set_acc(8'hb5);
        exec(14'h0e03, 8'ha5);
        e_acc = 8'h5a;
        check_core();
        `CHK("file_we", 1'b0, file_we_q)
        exec(14'h0e83, 8'h3c);
        `CHK("wdata", 8'hc3, file_wdata_q)
        check_core();
        exec(14'h0691, 8'haf);
        `CHK("wdata", 8'hf5, file_wdata_q)
        e_z = 1'b0;
        check_core();
        exec(14'h0611, 8'h5a);
        {e_acc, e_z} = {8'h00, 1'b1};
        check_core();
        idle();
    endtask

    task t_dir;
        set_acc(8'h3c);
        for (int i = 5; i < 8; i++) begin
            exec(14'h0060 | i[13:0], 8'h00);
            `CHK("dir_we", 1'b1, dir_we_q)
            `CHK("dir_sel", i[2:0], dir_sel_q)
            `CHK("dir_wdata", e_acc, dir_wdata_q)
            check_core();
        end
        idle();
        `CHK("dir_we", 1'b0, dir_we_q)
    endtask

    task t_sleep;
        int n;
        repeat (12) idle();
        // Counter must have moved, or the clear below proves nothing
        `CHK("watchdog_moving", 1'b1, watchdog_counter_q != 8'h00)
        exec(14'h0063, 8'h00);
        `CHK("sleep", 1'b1, sleep_q)
        `CHK("osc", 1'b0, osc_run_q)
        `CHK("timeout", 1'b1, timeout_flag_q)
        `CHK("powerdown", 1'b0, powerdown_flag_q)
        `CHK("watchdog", 8'h00, watchdog_counter_q)
        `CHK("prescaler", 2'h0, prescaler_q)
        exec(14'h3aff, 8'h00);
        idle();
        check_core();
        wake_pin = 1'b1;
        n = 0;
        while (sleep_q !== 1'b0 && n < 8) begin
            @(negedge clk);
            n++;
        end
        wake_pin = 1'b0;
        `CHK("osc", 1'b1, osc_run_q)
        `CHK("powerdown", 1'b0, powerdown_flag_q)
        set_acc(8'h42);
    endtask

    // ----------------------------------------
    // Clock, watchdog on the run, main sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            conclude();
        end
    end

    initial begin
        {rst, instr_valid, wake_pin, instr_word, file_rdata} = {3'b100, 14'h0000, 8'h00};
        {e_acc, e_c, e_dc, e_z} = 11'h000;
        n_errors = 0;
        checks_done = 0;
        cycles = 0;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_rotate();
        t_sub_lit();
        t_sub_file();
        t_swap_xor();
        t_dir();
        t_sleep();
        conclude();
    end
endmodule

`default_nettype wire
